// ---- src/dma_share_guard.sv ----
/*
 * Core-side support for DMA memory sharing and program read protection:
 * X/Y posted write buffers, next-cycle idle indications, protection flag,
 * wait-state hold, and an APB register pair for control and status.
 * Assumes outside glue multiplexes memory signals and halts the core via waitState.
 */
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module dma_share_guard
    import dma_share_pkg::*;
#(
    parameter int DEPTH = WBUF_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core pipeline requests
    input wire logic dataAccessNext,
    input wire logic progAccessNext,
    input wire logic xWrReq,
    input wire logic [MEM_AW-1:0] xWrAddr,
    input wire logic [MEM_DW-1:0] xWrData,
    input wire logic yWrReq,
    input wire logic [MEM_AW-1:0] yWrAddr,
    input wire logic [MEM_DW-1:0] yWrData,
    // Glue controls
    input wire logic waitState,
    input wire logic fetchFromExternal,
    input wire logic fetchIsMovp,
    // X and Y memory write ports
    output logic xMemWe,
    output logic [MEM_AW-1:0] xMemAddr,
    output logic [MEM_DW-1:0] xMemData,
    output logic yMemWe,
    output logic [MEM_AW-1:0] yMemAddr,
    output logic [MEM_DW-1:0] yMemData,
    // Indications toward DMA and glue
    output logic dataMemIdleNext,
    output logic progMemIdleNext,
    output logic xMemWbufFull,
    output logic yMemWbufFull,
    output logic protectedCopyFlag
);
    localparam int WW = MEM_AW + MEM_DW;

    typedef struct packed {
        logic stealEn;
        logic protEn;
        logic [31:0] rdata;
        logic dataRead;
        logic dataIdle;
        logic progIdle;
        logic protFlag;
        logic xWe;
        logic [WW-1:0] xWord;
        logic yWe;
        logic [WW-1:0] yWord;
    } guard_state_t;

    guard_state_t st_r;
    guard_state_t st_nxt;
    logic xPopValid;
    logic yPopValid;
    logic [WW-1:0] xHead;
    logic [WW-1:0] yHead;
    logic xEmpty;
    logic yEmpty;
    logic xPush;
    logic yPush;
    logic xPop;
    logic yPop;
    logic drainOk;
    logic setupPhase;
    logic accessPhase;
    logic addrHit;
    logic [31:0] statusWord;

    // ============================================================
    // Write buffers, one per data memory
    // Drain only while the core is running, not reading, and no DMA cycle is granted
    assign drainOk = !waitState && !st_r.dataRead && !st_r.dataIdle;
    assign xPush = xWrReq && !waitState;
    assign yPush = yWrReq && !waitState;
    assign xPop = drainOk && xPopValid;
    assign yPop = drainOk && yPopValid;

    write_buffer #(.WIDTH(WW), .DEPTH(DEPTH)) xBuf (
        .clk(clk),
        .arst_n(arst_n),
        .pushValid(xPush),
        .pushData({xWrAddr, xWrData}),
        .pushReady(),
        .popTake(xPop),
        .popValid(xPopValid),
        .popData(xHead),
        .full(xMemWbufFull),
        .empty(xEmpty)
    );

    write_buffer #(.WIDTH(WW), .DEPTH(DEPTH)) yBuf (
        .clk(clk),
        .arst_n(arst_n),
        .pushValid(yPush),
        .pushData({yWrAddr, yWrData}),
        .pushReady(),
        .popTake(yPop),
        .popValid(yPopValid),
        .popData(yHead),
        .full(yMemWbufFull),
        .empty(yEmpty)
    );

    // ============================================================
    // APB decode
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign addrHit = (paddr == OFS_CTRL) || (paddr == OFS_STATUS);
    assign pready = 1'b1;
    assign pslverr = accessPhase && !addrHit;
    assign prdata = st_r.rdata;

    always_comb begin
        statusWord = '0;
        statusWord[ST_XFULL_BIT] = xMemWbufFull;
        statusWord[ST_YFULL_BIT] = yMemWbufFull;
        statusWord[ST_XEMPTY_BIT] = xEmpty;
        statusWord[ST_YEMPTY_BIT] = yEmpty;
        statusWord[ST_DIDLE_BIT] = st_r.dataIdle;
        statusWord[ST_PIDLE_BIT] = st_r.progIdle;
        statusWord[ST_PROT_BIT] = st_r.protFlag;
    end

    // ============================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        if (setupPhase && !pwrite) begin
            st_nxt.rdata = '0;
            if (paddr == OFS_CTRL) begin
                st_nxt.rdata[CTRL_STEAL_BIT] = st_r.stealEn;
                st_nxt.rdata[CTRL_PROT_BIT] = st_r.protEn;
            end else if (paddr == OFS_STATUS) begin
                st_nxt.rdata = statusWord;
            end
        end
        if (accessPhase && pwrite && (paddr == OFS_CTRL)) begin
            st_nxt.stealEn = pwdata[CTRL_STEAL_BIT];
            st_nxt.protEn = pwdata[CTRL_PROT_BIT];
        end
        // Core-facing state freezes for the whole wait state
        if (!waitState) begin
            st_nxt.dataRead = dataAccessNext;
            // Idle only if both buffers are empty now and no write is posted this cycle
            st_nxt.dataIdle = st_r.stealEn && !dataAccessNext && xEmpty && yEmpty
                && !xWrReq && !yWrReq;
            st_nxt.progIdle = st_r.stealEn && !progAccessNext;
            st_nxt.protFlag = st_r.protEn && fetchFromExternal && fetchIsMovp;
            st_nxt.xWe = xPop;
            st_nxt.yWe = yPop;
            if (xPop) begin
                st_nxt.xWord = xHead;
            end
            if (yPop) begin
                st_nxt.yWord = yHead;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{stealEn: CTRL_STEAL_RESET, protEn: CTRL_PROT_RESET, rdata: RDATA_RESET, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // Outputs
    assign dataMemIdleNext = st_r.dataIdle;
    assign progMemIdleNext = st_r.progIdle;
    assign protectedCopyFlag = st_r.protFlag;
    assign xMemWe = st_r.xWe;
    assign xMemAddr = st_r.xWord[WW-1:MEM_DW];
    assign xMemData = st_r.xWord[MEM_DW-1:0];
    assign yMemWe = st_r.yWe;
    assign yMemAddr = st_r.yWord[WW-1:MEM_DW];
    assign yMemData = st_r.yWord[MEM_DW-1:0];

    // ============================================================
    // Checks
    AST_IDLE_DRAINED: assert property (@(posedge clk) disable iff (!arst_n)
        dataMemIdleNext |-> (xEmpty && yEmpty && !xMemWe && !yMemWe))
        else $error("data idle raised with write buffer not drained");
    AST_IDLE_AFTER_POST: assert property (@(posedge clk) disable iff (!arst_n)
        (!waitState && (xWrReq || yWrReq)) |=> !dataMemIdleNext)
        else $error("data idle raised right after a posted write");
    AST_DATA_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
        (!waitState && dataAccessNext) |=> !dataMemIdleNext)
        else $error("data idle raised while core accesses next cycle");
    AST_PROG_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
        (!waitState && st_r.stealEn && !progAccessNext) |=> progMemIdleNext)
        else $error("program idle missing when core skips program port");
    AST_PROG_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
        (!waitState && progAccessNext) |=> !progMemIdleNext)
        else $error("program idle raised while core fetches next cycle");
    AST_PROT_SET: assert property (@(posedge clk) disable iff (!arst_n)
        (!waitState && st_r.protEn && fetchFromExternal && fetchIsMovp) |=> protectedCopyFlag)
        else $error("protection flag missing on external program-to-data move");
    AST_PROT_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
        (!waitState && !fetchFromExternal) |=> !protectedCopyFlag)
        else $error("protection flag raised without external fetch");
    AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
        waitState |=> ($stable(dataMemIdleNext) && $stable(progMemIdleNext) && $stable(protectedCopyFlag)
            && $stable(xMemWe) && $stable(yMemWe) && $stable(xMemAddr) && $stable(xMemData)
            && $stable(yMemAddr) && $stable(yMemData)))
        else $error("core output changed during a wait state");
    AST_NO_WRITE_IN_DMA: assert property (@(posedge clk) disable iff (!arst_n)
        (!waitState && dataMemIdleNext) |=> (!xMemWe && !yMemWe))
        else $error("core write issued in a granted DMA cycle");
endmodule

// ---- src/dma_share_pkg.sv ----
/*
 * Constants shared by the memory share and fetch guard and its write buffer.
 * Assumes an APB master with 32-bit data and a single 40 MHz clock.
 */
// Function
// - Same sharing scheme for program and data memory ports.
// - Data idle indication asserted only with both write buffers drained.
// - Separate X and Y write buffer full indications are provided.
// - Idle indications mean the port is unused by the core next cycle.
// - External fetch of a program-to-data move raises the protection flag.
// - During a wait state every core output holds its value.
package dma_share_pkg;
    // ============================================================
    // Register map
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
    localparam int CTRL_STEAL_BIT = 0;
    localparam int CTRL_PROT_BIT = 1;
    localparam logic CTRL_STEAL_RESET = 1'h1;
    localparam logic CTRL_PROT_RESET = 1'h1;
    localparam int ST_XFULL_BIT = 0;
    localparam int ST_YFULL_BIT = 1;
    localparam int ST_XEMPTY_BIT = 2;
    localparam int ST_YEMPTY_BIT = 3;
    localparam int ST_DIDLE_BIT = 4;
    localparam int ST_PIDLE_BIT = 5;
    localparam int ST_PROT_BIT = 6;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ============================================================
    // Memory port shape
    localparam int MEM_AW = 16;
    localparam int MEM_DW = 16;
    localparam int WBUF_DEPTH = 2;
endpackage

// ---- src/write_buffer.sv ----
/*
 * Small write buffer holding posted core writes for one data memory.
 * Assumes the caller pops only while not empty and gates both sides in wait states.
 */
`timescale 1ns/100ps
module write_buffer
    import dma_share_pkg::*;
#(
    parameter int WIDTH = MEM_AW + MEM_DW,
    parameter int DEPTH = WBUF_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Fill side
    input wire logic pushValid,
    input wire logic [WIDTH-1:0] pushData,
    output logic pushReady,
    // Drain side
    input wire logic popTake,
    output logic popValid,
    output logic [WIDTH-1:0] popData,
    // Levels
    output logic full,
    output logic empty
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [CW-1:0] count;
    } wb_state_t;

    wb_state_t st_r;
    wb_state_t st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic doPush;
    logic doPop;

    function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
        if (p == PW'(DEPTH - 1)) begin
            return '0;
        end
        return p + PW'(1);
    endfunction

    assign full = (st_r.count == FULL_COUNT);
    assign empty = (st_r.count == '0);
    assign pushReady = !full;
    assign popValid = !empty;
    assign popData = mem[st_r.rdPtr];
    assign doPush = pushValid && !full;
    assign doPop = popTake && !empty;

    always_comb begin
        st_nxt = st_r;
        if (doPush) begin
            st_nxt.wrPtr = nextPtr(st_r.wrPtr);
        end
        if (doPop) begin
            st_nxt.rdPtr = nextPtr(st_r.rdPtr);
        end
        if (doPush && !doPop) begin
            st_nxt.count = st_r.count + CW'(1);
        end else if (doPop && !doPush) begin
            st_nxt.count = st_r.count - CW'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[st_r.wrPtr] <= pushData;
        end
    end

    AST_WB_FULL_REFUSE: assert property (@(posedge clk) disable iff (!arst_n)
        (full && pushValid && !popTake) |=> (full && $stable(st_r.wrPtr)))
        else $error("write buffer accepted a push while full");
    AST_WB_POP_COUNT: assert property (@(posedge clk) disable iff (!arst_n)
        (popTake && !empty && !pushValid) |=> (st_r.count == $past(st_r.count) - CW'(1)))
        else $error("write buffer count did not drop on pop");
endmodule

// ---- sim/dma_mem_model.sv ----
/*
 * Far-side model: X data memory behind the port multiplexer and a
 * cycle-stealing DMA engine that takes the port after an idle indication.
 * Assumes the guard's registered X write port and data idle indication.
 */
`timescale 1ns/100ps
module dma_mem_model
    import dma_share_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Core write port and indication
    input wire logic xMemWe,
    input wire logic [MEM_AW-1:0] xMemAddr,
    input wire logic [MEM_DW-1:0] xMemData,
    input wire logic dataMemIdleNext,
    // Observation
    output logic [MEM_AW-1:0] lastAddr,
    output logic [MEM_DW-1:0] lastData,
    output int steals,
    output int clashes
);
    logic dmaSel;

    // ============================================================
    // Multiplexer select and memory
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dmaSel <= 1'b0;
            lastAddr <= 16'h0000;
            lastData <= 16'h0000;
            steals <= 0;
            clashes <= 0;
        end else begin
            // Port goes to DMA only for the cycle after an idle indication
            dmaSel <= dataMemIdleNext;
            if (dmaSel) begin
                steals <= steals + 1;
            end
            // A core write inside a stolen cycle would be lost or stale
            if (dmaSel && xMemWe) begin
                clashes <= clashes + 1;
            end
            if (xMemWe && !dmaSel) begin
                lastAddr <= xMemAddr;
                lastData <= xMemData;
            end
        end
    end
endmodule

// ---- sim/tb_top.sv ----
/*
 * Bench for the memory share guard: APB registers, posted writes,
 * idle indications, protection flag and wait-state hold.
 * Assumes the far-side model dma_mem_model and a 40 MHz clock.
 */
`timescale 1ns/100ps
module tb_top
    import dma_share_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic dataAccessNext = 1'b0;
    logic progAccessNext = 1'b0;
    logic xWrReq = 1'b0;
    logic yWrReq = 1'b0;
    logic [MEM_AW-1:0] xWrAddr = '0;
    logic [MEM_AW-1:0] yWrAddr = '0;
    logic [MEM_DW-1:0] xWrData = '0;
    logic [MEM_DW-1:0] yWrData = '0;
    logic waitState = 1'b0;
    logic fetchFromExternal = 1'b0;
    logic fetchIsMovp = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, xMemWe, yMemWe, protectedCopyFlag;
    logic dataMemIdleNext, progMemIdleNext, xMemWbufFull, yMemWbufFull;
    logic [MEM_AW-1:0] xMemAddr, yMemAddr, lastAddr;
    logic [MEM_DW-1:0] xMemData, yMemData, lastData;
    int steals, clashes;
    int errTotal = 0;
    int nTests = 0;

    always #12.5 clk = ~clk;

    dma_share_guard #(.DEPTH(2)) i_dma_share_guard (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dataAccessNext(dataAccessNext), .progAccessNext(progAccessNext),
        .xWrReq(xWrReq), .xWrAddr(xWrAddr), .xWrData(xWrData),
        .yWrReq(yWrReq), .yWrAddr(yWrAddr), .yWrData(yWrData),
        .waitState(waitState), .fetchFromExternal(fetchFromExternal), .fetchIsMovp(fetchIsMovp),
        .xMemWe(xMemWe), .xMemAddr(xMemAddr), .xMemData(xMemData),
        .yMemWe(yMemWe), .yMemAddr(yMemAddr), .yMemData(yMemData),
        .dataMemIdleNext(dataMemIdleNext), .progMemIdleNext(progMemIdleNext),
        .xMemWbufFull(xMemWbufFull), .yMemWbufFull(yMemWbufFull),
        .protectedCopyFlag(protectedCopyFlag));

    dma_mem_model i_dma_mem_model (
        .clk(clk), .arst_n(arst_n), .xMemWe(xMemWe), .xMemAddr(xMemAddr), .xMemData(xMemData),
        .dataMemIdleNext(dataMemIdleNext), .lastAddr(lastAddr), .lastData(lastData),
        .steals(steals), .clashes(clashes));

    // ============================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        errTotal++;
        summarize();
    end

    // ============================================================
    // Tests
    initial begin
        logic [31:0] rd;
        logic er;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_CTRL, '0, rd, er);
        chk(rd, 32'h0000_0003);
        apb(1'b0, OFS_STATUS, '0, rd, er);
        chk(rd, 32'h0000_003C);
        apb(1'b0, 8'h08, '0, rd, er);
        chk({rd[30:0], er}, 32'h0000_0001);
        @(posedge clk);
        progAccessNext <= 1'b1;
        dataAccessNext <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(32'({dataMemIdleNext, progMemIdleNext}), 32'h0000_0000);
        @(posedge clk);
        progAccessNext <= 1'b0;
        dataAccessNext <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(32'({dataMemIdleNext, progMemIdleNext}), 32'h0000_0003);
        // Posted writes on both data ports
        @(posedge clk);
        xWrReq <= 1'b1;
        yWrReq <= 1'b1;
        {xWrAddr, xWrData} <= 32'h0012_00A5;
        {yWrAddr, yWrData} <= 32'h0034_005A;
        @(posedge clk);
        xWrReq <= 1'b0;
        yWrReq <= 1'b0;
        @(negedge clk);
        chk(32'({xMemWe, dataMemIdleNext}), 32'h0000_0000);
        @(negedge clk);
        chk(32'({xMemWe, yMemWe}), 32'h0000_0003);
        chk({yMemAddr, yMemData}, 32'h0034_005A);
        @(negedge clk);
        chk({lastAddr, lastData}, 32'h0012_00A5);
        // Fill X buffer while core reads block draining
        @(posedge clk);
        dataAccessNext <= 1'b1;
        for (int i = 1; i <= 3; i++) begin
            @(posedge clk);
            xWrReq <= 1'b1;
            xWrData <= 16'(i);
        end
        @(posedge clk);
        xWrReq <= 1'b0;
        @(negedge clk);
        chk(32'({xMemWbufFull, yMemWbufFull, dataMemIdleNext}), 32'h0000_0004);
        @(posedge clk);
        dataAccessNext <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({lastAddr, lastData}, 32'h0012_0002);
        chk(32'({clashes == 0, steals > 0}), 32'h0000_0003);
        // Protection flag over all fetch combinations
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {fetchFromExternal, fetchIsMovp} <= 2'(i);
            @(posedge clk);
            @(negedge clk);
            chk(32'(protectedCopyFlag), 32'(i == 3));
        end
        // Wait state freezes outputs
        @(posedge clk);
        waitState <= 1'b1;
        fetchIsMovp <= 1'b0;
        progAccessNext <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(32'({protectedCopyFlag, progMemIdleNext}), 32'h0000_0003);
        @(posedge clk);
        waitState <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(32'({protectedCopyFlag, progMemIdleNext}), 32'h0000_0000);
        // Both enables cleared
        apb(1'b1, OFS_CTRL, 32'h0000_0000, rd, er);
        @(posedge clk);
        progAccessNext <= 1'b0;
        fetchIsMovp <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(32'({protectedCopyFlag, dataMemIdleNext, progMemIdleNext}), 32'h0000_0000);
        apb(1'b0, OFS_CTRL, '0, rd, er);
        chk(rd, 32'h0000_0000);
        summarize();
    end
endmodule
